// File: design/event_mask_flag_and_mode_monitor.v
// event mask, flag and operating mode registers of the receiver
`include "event_monitor_consts.vh"

module event_mask_flag_and_mode_monitor (
    // clock and reset
    input  wire       i_ref_clk,
    input  wire       i_rst_n,
    // register access
    input  wire [7:0] i_reg_addr,
    input  wire       i_reg_wr,
    input  wire       i_reg_rd,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    // event sources
    input  wire       i_rx_data_event,
    input  wire       i_charge_state_event,
    input  wire       i_converter_overcurrent,
    input  wire       i_regulator_limit,
    input  wire [3:0] i_operating_mode_code,
    // decoded mode
    output reg        o_mode_shutdown,
    output reg        o_mode_charge1,
    output reg        o_mode_charge2,
    output reg        o_mode_discharge
);

    localparam [3:0] FLAGS_INIT  = `FLAGS_RESET;
    localparam [3:0] DECODE_INIT = `MODE_DECODE_RESET;

    // register contents and their next values
    reg  [3:0] mask_q;
    reg  [3:0] mask_d;
    reg        rx_flag_q;
    reg        rx_flag_d;
    reg        charge_flag_q;
    reg        charge_flag_d;
    reg        overcurrent_flag_q;
    reg        overcurrent_flag_d;
    reg        limit_flag_q;
    reg        limit_flag_d;
    reg  [3:0] mode_q;
    reg  [3:0] mode_d;
    reg  [7:0] rdata_d;
    reg        shutdown_d;
    reg        charge1_d;
    reg        charge2_d;
    reg        discharge_d;
    // register selects
    reg        sel_rsvd_a;
    reg        sel_rsvd_b;
    reg        sel_mask;
    reg        sel_flags;
    reg        sel_mode;
    // strobes, qualified events and the flag word
    wire       mask_write;
    wire       flags_read;
    wire       rx_data_hit;
    wire       charge_change_hit;
    wire       overcurrent_live;
    wire       limit_live;
    wire [3:0] flags_word;

    // true when the bus address selects the given register
    function addr_is;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_is = (addr == target);
        end
    endfunction

    // an event reaches its flag only while its mask bit is clear
    function notify;
        input source;
        input mask_bit;
        begin
            notify = source && !mask_bit;
        end
    endfunction

    // field in the low nibble, upper bits read as zero
    function [7:0] pad_field;
        input [3:0] field;
        begin
            pad_field = {`FIELD_PAD, field};
        end
    endfunction

    // mode code classes
    function mode_is_shutdown;
        input [3:0] code;
        begin
            mode_is_shutdown = (code < `MODE_CHARGE1_MIN);
        end
    endfunction

    function mode_is_charge1;
        input [3:0] code;
        begin
            mode_is_charge1 = (code >= `MODE_CHARGE1_MIN) && (code <= `MODE_CHARGE1_MAX);
        end
    endfunction

    function mode_is_charge2;
        input [3:0] code;
        begin
            mode_is_charge2 = (code == `MODE_CHARGE2);
        end
    endfunction

    function mode_is_discharge;
        input [3:0] code;
        begin
            mode_is_discharge = (code == `MODE_DISCHARGE);
        end
    endfunction

    // at most one select is high
    always @* begin
        sel_rsvd_a = 1'b0;
        sel_rsvd_b = 1'b0;
        sel_mask   = 1'b0;
        sel_flags  = 1'b0;
        sel_mode   = 1'b0;
        if (addr_is(i_reg_addr, `ADDR_RESERVED_BLOCK_A)) begin
            sel_rsvd_a = 1'b1;
        end else if (addr_is(i_reg_addr, `ADDR_RESERVED_BLOCK_B)) begin
            sel_rsvd_b = 1'b1;
        end else if (addr_is(i_reg_addr, `ADDR_EVENT_NOTIFY_MASK)) begin
            sel_mask = 1'b1;
        end else if (addr_is(i_reg_addr, `ADDR_EVENT_FLAGS)) begin
            sel_flags = 1'b1;
        end else if (addr_is(i_reg_addr, `ADDR_OPERATING_MODE)) begin
            sel_mode = 1'b1;
        end
    end

    assign mask_write        = i_reg_wr && sel_mask;
    assign flags_read        = i_reg_rd && sel_flags;
    assign rx_data_hit       = notify(i_rx_data_event, mask_q[`BIT_RX_DATA]); // R1
    assign charge_change_hit = notify(i_charge_state_event, mask_q[`BIT_CHARGE_CHANGE]); // R2
    assign overcurrent_live  = notify(i_converter_overcurrent,
                                      mask_q[`BIT_CONV_OVERCURRENT]); // R3
    assign limit_live        = notify(i_regulator_limit, mask_q[`BIT_REG_LIMIT]); // R4
    assign flags_word        = {limit_flag_q, overcurrent_flag_q, charge_flag_q, rx_flag_q};

    // writes land only in the four mask bits
    always @* begin
        mask_d = mask_q;
        if (mask_write) begin
            mask_d = i_reg_wdata[3:0]; // R11
        end
    end

    // read clears latched events; a new event in the same cycle wins
    always @* begin
        rx_flag_d = rx_flag_q;
        if (flags_read) begin
            rx_flag_d = 1'b0; // R5
        end
        if (rx_data_hit) begin
            rx_flag_d = 1'b1; // R5
        end
    end

    always @* begin
        charge_flag_d = charge_flag_q;
        if (flags_read) begin
            charge_flag_d = 1'b0; // R6
        end
        if (charge_change_hit) begin
            charge_flag_d = 1'b1; // R6
        end
    end

    // level flags follow their detector and ignore the read
    always @* begin
        overcurrent_flag_d = overcurrent_live; // R7
    end

    always @* begin
        limit_flag_d = limit_live; // R8
    end

    // code is sampled, then classified a cycle later
    always @* begin
        mode_d = i_operating_mode_code; // R9
    end

    always @* begin
        shutdown_d = mode_is_shutdown(mode_q); // R9
    end

    always @* begin
        charge1_d = mode_is_charge1(mode_q); // R9
    end

    always @* begin
        charge2_d = mode_is_charge2(mode_q); // R9
    end

    always @* begin
        discharge_d = mode_is_discharge(mode_q); // R9
    end

    // unmapped and reserved addresses read as zero
    always @* begin
        rdata_d = `RSVD_READ_VALUE; // R11
        if (sel_mask) begin
            rdata_d = pad_field(mask_q); // R11
        end else if (sel_flags) begin
            rdata_d = pad_field(flags_word); // R11
        end else if (sel_mode) begin
            rdata_d = pad_field(mode_q); // R10
        end else if (sel_rsvd_a || sel_rsvd_b) begin
            rdata_d = `RSVD_READ_VALUE; // R11
        end
    end

    // storage: synchronous reset, one process per register
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            mask_q <= `MASK_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rx_flag_q <= FLAGS_INIT[`BIT_RX_DATA];
        end else begin
            rx_flag_q <= rx_flag_d;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            charge_flag_q <= FLAGS_INIT[`BIT_CHARGE_CHANGE];
        end else begin
            charge_flag_q <= charge_flag_d;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            overcurrent_flag_q <= FLAGS_INIT[`BIT_CONV_OVERCURRENT];
        end else begin
            overcurrent_flag_q <= overcurrent_flag_d;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            limit_flag_q <= FLAGS_INIT[`BIT_REG_LIMIT];
        end else begin
            limit_flag_q <= limit_flag_d;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            mode_q <= `MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    // read data lags the address by one cycle
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata <= `RDATA_RESET;
        end else begin
            o_reg_rdata <= rdata_d;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_mode_shutdown <= DECODE_INIT[`DEC_SHUTDOWN];
        end else begin
            o_mode_shutdown <= shutdown_d;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_mode_charge1 <= DECODE_INIT[`DEC_CHARGE1];
        end else begin
            o_mode_charge1 <= charge1_d;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_mode_charge2 <= DECODE_INIT[`DEC_CHARGE2];
        end else begin
            o_mode_charge2 <= charge2_d;
        end
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_mode_discharge <= DECODE_INIT[`DEC_DISCHARGE];
        end else begin
            o_mode_discharge <= discharge_d;
        end
    end

endmodule

// File: design/event_monitor_consts.vh
// register offsets, field positions and mode codes of the event monitor
// Summary of operation
// R1: mask bit 0 set to 1 keeps the data-received event from raising its flag, 0 lets it through.
// R2: mask bit 1 set to 1 keeps a charge state change from raising its flag, 0 lets it through.
// R3: mask bit 2 set to 1 keeps converter overcurrent from showing in its flag, 0 lets it through.
// R4: mask bit 3 set to 1 keeps regulator current limit from showing in its flag, 0 lets it through.
// R5: flag bit 0 is set when wireless data arrives and clears after the flag register is read.
// R6: flag bit 1 is set on a charge state change and clears after the flag register is read.
// R7: flag bit 2 reads 1 while converter overcurrent is detected and is not cleared by a read.
// R8: flag bit 3 reads 1 while the regulator is current limiting and is not cleared by a read.
// R9: the mode code reads 0 or 1 for shutdown, 2 to 7 charge mode 1, 8 charge mode 2, 9 discharge.
// R10: the mode code is a four-bit field at bit 0 of its register.
// R11: reserved and unused bits read as zero and ignore writes.
`ifndef EVENT_MONITOR_CONSTS_VH
`define EVENT_MONITOR_CONSTS_VH

`define ADDR_RESERVED_BLOCK_A   8'h2D
`define ADDR_RESERVED_BLOCK_B   8'h2E
`define ADDR_EVENT_NOTIFY_MASK  8'h2F
`define ADDR_EVENT_FLAGS        8'h30
`define ADDR_OPERATING_MODE     8'h31

`define BIT_RX_DATA             0
`define BIT_CHARGE_CHANGE       1
`define BIT_CONV_OVERCURRENT    2
`define BIT_REG_LIMIT           3

`define EVENT_FIELD_MASK        8'h0F
`define MASK_RESET              4'h0
`define FLAGS_RESET             4'h0
`define MODE_RESET              4'h0
`define RDATA_RESET             8'h00
`define RSVD_READ_VALUE         8'h00
`define FIELD_PAD               4'h0
`define MODE_DECODE_RESET       4'h8
`define DEC_SHUTDOWN            3
`define DEC_CHARGE1             2
`define DEC_CHARGE2             1
`define DEC_DISCHARGE           0

`define MODE_CHARGE1_MIN        4'h2
`define MODE_CHARGE1_MAX        4'h7
`define MODE_CHARGE2            4'h8
`define MODE_DISCHARGE          4'h9

`endif

// File: testbench/event_host.sv
// host model: requests start after an edge and are held until sampled
module event_host(input wire logic i_ref_clk, input wire logic [7:0] o_reg_rdata,
    output logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00,
    output logic i_reg_wr = 1'b0, i_reg_rd = 1'b0);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic wr(input logic [7:0] a, v);
        @(posedge i_ref_clk) #1 {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, v, 1'b1};
        @(posedge i_ref_clk) #1 i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_ref_clk) #1 {i_reg_addr, i_reg_rd} = {a, 1'b1};
        @(posedge i_ref_clk) #1 {v, i_reg_rd} = {o_reg_rdata, 1'b0};
    endtask
endmodule

// File: testbench/event_monitor_checker.sv
// port checks of the event monitor
module event_monitor_checker(input wire logic i_ref_clk, i_rst_n, i_reg_wr, i_reg_rd,
    i_rx_data_event, i_charge_state_event, i_converter_overcurrent, o_mode_charge1,
    o_mode_charge2, input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
    input wire logic [3:0] i_operating_mode_code);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    upper_zero_a: assert property (o_reg_rdata[7:4] == 4'h0) else $error("upper");
    rsvd_zero_a: assert property ($past(i_reg_addr) inside {8'h2D, 8'h2E}
        |-> o_reg_rdata == 8'h00) else $error("reserved");
    read_clear_a: assert property (i_reg_rd && i_reg_addr == 8'h30 && !i_rx_data_event
        && !i_charge_state_event ##1 i_reg_addr == 8'h30 |=> o_reg_rdata[1:0] == 2'b00)
        else $error("clear");
    mask_wr_a: assert property (i_reg_wr && i_reg_addr == 8'h2F ##1 i_reg_addr == 8'h2F
        && !i_reg_wr |=> o_reg_rdata == {4'h0, $past(i_reg_wdata[3:0], 2)}) else $error("mask");
    oc_live_a: assert property ($past(i_reg_addr) == 8'h30 && o_reg_rdata[2]
        |-> $past(i_converter_overcurrent, 2)) else $error("oc");
    mode_read_a: assert property ($past(i_rst_n, 2) && $past(i_reg_addr) == 8'h31
        |-> o_reg_rdata == {4'h0, $past(i_operating_mode_code, 2)}) else $error("mode");
    charge_one_a: assert property ($past(i_rst_n, 2) |-> o_mode_charge1 ==
        ($past(i_operating_mode_code, 2) inside {[4'h2:4'h7]})) else $error("charge1");
    charge_two_a: assert property ($past(i_rst_n, 2) |-> o_mode_charge2 ==
        ($past(i_operating_mode_code, 2) == 4'h8)) else $error("charge2");
    cover property (i_reg_rd && i_reg_addr == 8'h30);
    cover property (i_reg_wr && i_reg_addr == 8'h2F);
    cover property (o_mode_charge2);
endmodule
bind event_mask_flag_and_mode_monitor event_monitor_checker chk(.*);

// File: testbench/event_mask_flag_and_mode_monitor_test.sv
// self-checking bench for the event monitor
module event_mask_flag_and_mode_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_rx_data_event = 1'b0, i_charge_state_event = 1'b0;
    logic i_converter_overcurrent = 1'b0, i_regulator_limit = 1'b0, i_reg_wr, i_reg_rd;
    logic o_mode_shutdown, o_mode_charge1, o_mode_charge2, o_mode_discharge;
    logic [3:0] i_operating_mode_code = 4'h0;
    logic [3:0] masks[4] = '{4'hF, 4'h0, 4'h5, 4'hA};
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d;
    int errors = 0, samples_checked = 0, cyc = 0;
    event_host host(.*);
    event_mask_flag_and_mode_monitor dut(.*);
    initial forever #2.5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) if (++cyc > 1000) begin
        errors++;
        stop_test();
    end
    task automatic cmp(input logic [7:0] g, e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk(input logic [7:0] a, e);
        host.rd(a, d);
        cmp(d, e);
    endtask
    task automatic test_regs();
        for (int a = 8'h2D; a < 8'h32; a++) chk(8'(a), 8'h00);
        host.wr(8'h2D, 8'hFF);
        chk(8'h2D, 8'h00);
        host.wr(8'h2F, 8'hFF);
        chk(8'h2F, 8'h0F);
        $display("test_regs done");
    endtask
    task automatic test_flags();
        {i_converter_overcurrent, i_regulator_limit} = 2'b11;
        foreach (masks[i]) begin
            host.wr(8'h2F, {4'h0, masks[i]});
            @(posedge i_ref_clk) #1 {i_rx_data_event, i_charge_state_event} = 2'b11;
            @(posedge i_ref_clk) #1 {i_rx_data_event, i_charge_state_event} = 2'b00;
            chk(8'h30, {4'h0, ~masks[i]});
            chk(8'h30, {4'h0, ~masks[i][3:2], 2'b00});
        end
        host.wr(8'h2F, 8'h00);
        {i_converter_overcurrent, i_regulator_limit} = 2'b00;
        chk(8'h30, 8'h00);
        $display("test_flags done");
    endtask
    task automatic test_mode();
        for (int c = 0; c < 11; c++) begin
            @(posedge i_ref_clk) #1 i_operating_mode_code = 4'(c);
            chk(8'h31, 8'(c));
            cmp({o_mode_shutdown, o_mode_charge1, o_mode_charge2, o_mode_discharge},
                {c < 2, c > 1 && c < 8, c == 8, c == 9});
        end
        $display("test_mode done");
    endtask
    task automatic stop_test();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_ref_clk);
        #1 i_rst_n = 1'b1;
        test_regs();
        test_flags();
        test_mode();
        stop_test();
    end
endmodule
